// *** core/port_mode_pkg.sv ***
// package for the port pin mode control block
// assumes a byte-wide cpu register file access with 8-bit addresses
package port_mode_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_A_LOW_PIN_MODES  = 8'hED;
    localparam logic [7:0] ADDR_PORT_B_HIGH_PIN_MODES = 8'hEE;
    localparam logic [7:0] ADDR_PORT_B_LOW_PIN_MODES  = 8'hEF;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_REG_RESET = 8'h00;
    localparam int         MODE_W         = 2;
    localparam int         PORT_B_PINS    = 8;
    localparam int         PORT_A_PIN0_LO = 0;

    // ------------------------------------------------------------
    // mode field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_INPUT      = 2'h0;
    localparam logic [1:0] MODE_INPUT_PU   = 2'h1;
    localparam logic [1:0] MODE_OPEN_DRAIN = 2'h2;
    localparam logic [1:0] MODE_PUSH_PULL  = 2'h3;

    // pin buffer controls for one pin
    typedef struct packed {
        logic pull_up;    // weak pull-up on
        logic drive_en;   // output buffer enabled
        logic open_drain; // drive low only
    } pin_ctrl_s;

    localparam pin_ctrl_s PIN_CTRL_RESET = '{pull_up: 1'b0, drive_en: 1'b0, open_drain: 1'b0};

endpackage

// *** core/port_pin_mode_control.sv ***
// pin mode control registers and pin buffer decode for port b and pin 0 of port a
// assumes cpu register accesses are single-cycle strobes synchronous to clk_i
`timescale 1ns/1ps

module port_pin_mode_control
    import port_mode_pkg::*;
#(
    parameter int PINS = PORT_B_PINS
) (
    input  wire logic                 clk_i,          // 25 mhz system clock
    input  wire logic                 reset_n_i,      // async chip reset, active low
    input  wire logic [7:0]           reg_addr_i,     // register file address
    input  wire logic                 reg_wr_i,       // write strobe
    input  wire logic                 reg_rd_i,       // read strobe
    input  wire logic                 reg_direct_i,   // access uses register addressing
    input  wire logic [7:0]           reg_wdata_i,    // write data
    output logic      [7:0]           reg_rdata_o,    // read data
    output logic                      reg_rvalid_o,   // read data valid pulse
    output pin_ctrl_s [PINS-1:0]      port_b_ctrl_o,  // port b pin buffer controls
    output pin_ctrl_s                 port_a_pin0_o   // port a pin0 buffer controls
);

    // ------------------------------------------------------------
    // mode registers
    // ------------------------------------------------------------
    logic [7:0]           port_b_high_pin_modes_reg;
    logic [7:0]           port_b_low_pin_modes_reg;
    logic [7:0]           port_a_low_pin_modes_reg;
    logic [2*PINS-1:0]    port_b_modes;
    pin_ctrl_s [PINS-1:0] port_b_ctrl_next;
    pin_ctrl_s            port_a_pin0_next;

    // decode of accesses; non-direct accesses are ignored
    wire logic access_ok = reg_direct_i;
    wire logic sel_b_hi  = reg_addr_i == ADDR_PORT_B_HIGH_PIN_MODES;
    wire logic sel_b_lo  = reg_addr_i == ADDR_PORT_B_LOW_PIN_MODES;
    wire logic sel_a_lo  = reg_addr_i == ADDR_PORT_A_LOW_PIN_MODES;
    wire logic sel_any   = sel_b_hi | sel_b_lo | sel_a_lo;
    wire logic wr_b_hi   = reg_wr_i & access_ok & sel_b_hi;
    wire logic wr_b_lo   = reg_wr_i & access_ok & sel_b_lo;
    wire logic wr_a_lo   = reg_wr_i & access_ok & sel_a_lo;
    wire logic rd_hit    = reg_rd_i & access_ok & sel_any;

    // read data selection
    wire logic [7:0] rd_mux = sel_b_hi ? port_b_high_pin_modes_reg :
                              sel_b_lo ? port_b_low_pin_modes_reg  :
                              sel_a_lo ? port_a_low_pin_modes_reg  : 8'h00;

    // register writes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port_b_high_pin_modes_reg <= MODE_REG_RESET;
            port_b_low_pin_modes_reg  <= MODE_REG_RESET;
            port_a_low_pin_modes_reg  <= MODE_REG_RESET;
        end else begin
            if (wr_b_hi) begin
                port_b_high_pin_modes_reg <= reg_wdata_i;
            end
            if (wr_b_lo) begin
                port_b_low_pin_modes_reg <= reg_wdata_i;
            end
            if (wr_a_lo) begin
                port_a_low_pin_modes_reg <= reg_wdata_i;
            end
        end
    end

    // read answer, one cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= rd_hit;
            reg_rdata_o  <= rd_hit ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // pin i uses bits 2i+1:2i of {high, low}; pin3 lands on low bits 7-6
    assign port_b_modes = {port_b_high_pin_modes_reg, port_b_low_pin_modes_reg};

    // four-way mode decode to buffer controls
    function automatic pin_ctrl_s decode_mode(input logic [1:0] mode);
        pin_ctrl_s c;
        c.pull_up    = (mode == MODE_INPUT_PU);
        c.drive_en   = (mode == MODE_OPEN_DRAIN) | (mode == MODE_PUSH_PULL);
        c.open_drain = (mode == MODE_OPEN_DRAIN);
        return c;
    endfunction

    // one decoder per port b pin
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        assign port_b_ctrl_next[i] = decode_mode(port_b_modes[2*i +: MODE_W]);
    end

    // port a pin0 shares the same encoding
    assign port_a_pin0_next = decode_mode(
        port_a_low_pin_modes_reg[PORT_A_PIN0_LO +: MODE_W]);

    // registered pin controls, plain input after reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port_b_ctrl_o <= {PINS{PIN_CTRL_RESET}};
            port_a_pin0_o <= PIN_CTRL_RESET;
        end else begin
            port_b_ctrl_o <= port_b_ctrl_next;
            port_a_pin0_o <= port_a_pin0_next;
        end
    end

endmodule

// *** tb/port_pin_mode_control_chk.sv ***
// assertions on the pin mode control ports
// assumes a bind onto port_pin_mode_control
`timescale 1ns/1ps
module port_pin_mode_control_chk
    import port_mode_pkg::*;
#(parameter int PINS = PORT_B_PINS) (
    input wire logic            clk_i,         // clock
    input wire logic            reset_n_i,     // reset, active low
    input wire logic [7:0]      reg_addr_i,    // address
    input wire logic            reg_wr_i,      // write strobe
    input wire logic            reg_direct_i,  // direct access
    input wire logic [7:0]      reg_wdata_i,   // write data
    input pin_ctrl_s [PINS-1:0] port_b_ctrl_o, // port b controls
    input pin_ctrl_s            port_a_pin0_o  // port a pin0 controls
);
    // expected controls of bit pair i of d
    function automatic pin_ctrl_s f(logic [7:0] d, int i);
        return '{pull_up: d[2*i+:2] == 2'h1, drive_en: d[2*i+1], open_drain: d[2*i+:2] == 2'h2};
    endfunction
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire w = reg_wr_i && reg_direct_i; // accepted write
    property p_b3; w && reg_addr_i == 8'hEF |-> ##2 port_b_ctrl_o[3] == f($past(reg_wdata_i, 2), 3); endproperty
    a_b3: assert property (p_b3) else $error("pin3 mode wrong");
    property p_b0; w && reg_addr_i == 8'hEF |-> ##2 port_b_ctrl_o[0] == f($past(reg_wdata_i, 2), 0); endproperty
    a_b0: assert property (p_b0) else $error("pin0 mode wrong");
    property p_b7; w && reg_addr_i == 8'hEE |-> ##2 port_b_ctrl_o[7] == f($past(reg_wdata_i, 2), 3); endproperty
    a_b7: assert property (p_b7) else $error("pin7 mode wrong");
    property p_a0; w && reg_addr_i == 8'hED |-> ##2 port_a_pin0_o == f($past(reg_wdata_i, 2), 0); endproperty
    a_a0: assert property (p_a0) else $error("port a pin0 mode wrong");
    property p_rst; $rose(reset_n_i) |-> port_b_ctrl_o == '0 && port_a_pin0_o == '0; endproperty
    a_rst: assert property (p_rst) else $error("pins not input after reset");
endmodule

// *** tb/port_pin_mode_control_tb.sv ***
// self-checking bench for the pin mode control block
// assumes the checker file is compiled first
`timescale 1ns/1ps
module port_pin_mode_control_tb;
    import port_mode_pkg::*;
    logic clk_i = 0, reset_n_i = 0, wr = 0, rd = 0, dir = 0, rvalid;
    logic [7:0] addr = 0, wd = 0, rdata;
    pin_ctrl_s [7:0] pb;
    pin_ctrl_s pa;
    int errors = 0, checked = 0, i;
    always #20 clk_i = ~clk_i;
    port_pin_mode_control i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_direct_i(dir), .reg_wdata_i(wd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .port_b_ctrl_o(pb), .port_a_pin0_o(pa));
    task automatic cmp(logic [23:0] got, logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [23:0] dec(logic [1:0] m);
        return {21'h0, m == 2'h1, m[1], m == 2'h2};
    endfunction
    task automatic wr_reg(logic [7:0] a, logic [7:0] d, logic dr);
        @(posedge clk_i) #1;
        {addr, wd, dir, wr} = {a, d, dr, 1'b1};
        @(posedge clk_i) #1;
        wr = 0;
    endtask
    task automatic rd_reg(logic [7:0] a, logic [7:0] e, logic ev);
        @(posedge clk_i) #1;
        {addr, dir, rd} = {a, 2'b11};
        @(posedge clk_i) #1;
        rd = 0;
        cmp({rvalid, rdata}, {ev, ev ? e : 8'h00});
    endtask
    task automatic ck_pins(logic [7:0] lo, logic [7:0] hi, logic [1:0] am);
        repeat (2) @(posedge clk_i);
        #1;
        for (i = 0; i < 4; i++) begin
            cmp(pb[i], dec(lo[2*i+:2]));
            cmp(pb[i+4], dec(hi[2*i+:2]));
        end
        cmp(pa, dec(am));
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        #1 reset_n_i = 1;
        rd_reg(8'hEE, 8'h00, 1);
        rd_reg(8'hEF, 8'h00, 1);
        ck_pins(8'h00, 8'h00, 2'h0);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            wr_reg(8'hEF, {4{m[1:0]}}, 1);
            wr_reg(8'hEE, {4{m[1:0]}}, 1);
            wr_reg(8'hED, {6'h00, m[1:0]}, 1);
            ck_pins({4{m[1:0]}}, {4{m[1:0]}}, m[1:0]);
        end
        $display("test modes done");
        wr_reg(8'hEF, 8'hE4, 1);
        wr_reg(8'hEE, 8'h1B, 1);
        wr_reg(8'hEF, 8'hFF, 0);
        wr_reg(8'hEC, 8'hFF, 1);
        ck_pins(8'hE4, 8'h1B, 2'h3);
        rd_reg(8'hEF, 8'hE4, 1);
        rd_reg(8'hEC, 8'h00, 0);
        $display("test fields done");
        reset_n_i = 0;
        @(posedge clk_i) #1;
        cmp(pb, 24'h000000);
        cmp(pa, 24'h000000);
        reset_n_i = 1;
        rd_reg(8'hED, 8'h00, 1);
        $display("test second reset done");
        print_verdict;
    end
    task automatic print_verdict;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
endmodule
bind port_pin_mode_control port_pin_mode_control_chk #(.PINS(PINS)) i_chk (.*);
